// ### rtl/global_control_config_swap.sv
`timescale 1ns/10ps
// Notes on behaviour
// - read-only 8-bit revision code; low nibble steps per silicon revision.
// - first view register returns live composite interrupt inputs 0 to 15.
// - second view register returns live composite interrupt inputs 16 to 31.
// - while master-reset bit is 1, all device flip-flops except that bit and the read data stay in reset.
// - writing 0 to master-reset bit releases reset, operation resumes.
// - swap lock blocks outgoing swap pulses; request delta keeps working.
// - busy mask gates busy delta into the interrupt output.
// - request mask gates request delta into the interrupt output.
// - request delta sets on any request, from pin or trigger register.
// - busy is high from swap pulse until the next frame boundary.
// - busy delta sets when busy falls, marking swap completion.
// - trigger write asks standby maps to become active at frame boundary.
// - trigger register is write-only; each write makes a one-cycle pulse.
// - delta bits are read-only and clear when read.
module global_control_config_swap
    import gcc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gcc_pkg::ADDR_W-1:0] paddr,
    input wire logic [gcc_pkg::DATA_W-1:0] pwdata,
    output logic [gcc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [gcc_pkg::IRQ_IN_W-1:0] compositeIrq,
    input wire logic swapRequestPin,
    input wire logic frameBoundary,
    output logic swapPulseOut,
    output logic deviceReset,
    output logic irqOut
);
    localparam logic [REV_W-1:0] REVISION_CODE = REVISION_DEFAULT;

    // register file state
    logic softReset;
    logic requestMask;
    logic busyMask;
    logic swapLock;
    logic swapHold;
    logic requestDelta;
    logic busyDelta;
    logic irqReg;
    logic [DATA_W-1:0] readData;
    logic next_softReset;
    logic next_requestMask;
    logic next_busyMask;
    logic next_swapLock;
    logic next_swapHold;
    logic next_requestDelta;
    logic next_busyDelta;
    logic next_irqReg;
    logic [DATA_W-1:0] next_readData;

    // bus decode
    logic access;
    logic writeAccess;
    logic readAccess;
    logic [ADDR_W-3:0] regIndex;
    logic addrAligned;
    logic mapped;
    logic coreRst;

    // request path
    logic triggerPulse;
    logic pinRise;
    logic swapRequest;
    logic swapBusy;
    logic busyFell;

    // zero wait states: every access completes in its first access cycle
    assign access = psel & penable;
    assign writeAccess = access & pwrite;
    assign readAccess = access & ~pwrite;
    assign regIndex = paddr[ADDR_W-1:2];
    assign addrAligned = (paddr[1:0] == 2'h0);

    always_comb begin
        mapped = 1'b0;
        if (addrAligned) begin
            case ({2'h0, regIndex})
                IDX_REVISION, IDX_IRQ_LOW, IDX_IRQ_HIGH, IDX_SOFT_RESET,
                IDX_SWAP_CONTROL, IDX_REQ_DELTA, IDX_BUSY_DELTA,
                IDX_SWAP_TRIGGER: begin
                    mapped = 1'b1;
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = readData;

    // soft reset holds the rest in reset
    assign coreRst = srst | softReset;
    assign deviceReset = coreRst;

    assign triggerPulse = writeAccess && mapped
        && ({2'h0, regIndex} == IDX_SWAP_TRIGGER);
    assign swapRequest = triggerPulse | pinRise;

    // neighbouring device pin is asynchronous to clk
    pin_sync u_pin_sync (
        .clk(clk),
        .rst(coreRst),
        .pinIn(swapRequestPin),
        .levelOut(),
        .risePulse(pinRise)
    );

    swap_sequencer u_swap_sequencer (
        .clk(clk),
        .rst(coreRst),
        .request(swapRequest),
        .swapLock(swapLock),
        .frameBoundary(frameBoundary),
        .swapPulse(swapPulseOut),
        .swapBusy(swapBusy),
        .busyFell(busyFell)
    );

    // soft reset bit lives on srst only, so software can release it
    always_comb begin
        next_softReset = softReset;
        if (writeAccess && ({2'h0, regIndex} == IDX_SOFT_RESET)
            && addrAligned) begin
            next_softReset = pwdata[BIT_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            softReset <= RST_SOFT_RESET;
        end else begin
            softReset <= next_softReset;
        end
    end

    // control bits, deltas, interrupt and read data
    always_comb begin
        next_requestMask = requestMask;
        next_busyMask = busyMask;
        next_swapLock = swapLock;
        next_swapHold = swapHold;
        next_requestDelta = requestDelta;
        next_busyDelta = busyDelta;
        next_readData = readData;
        if (writeAccess && mapped
            && ({2'h0, regIndex} == IDX_SWAP_CONTROL)) begin
            next_requestMask = pwdata[BIT_REQ_MASK];
            next_swapLock = pwdata[BIT_LOCK];
            next_swapHold = pwdata[BIT_HOLD];
            next_busyMask = pwdata[BIT_BUSY_MASK];
        end
        if (readAccess && mapped
            && ({2'h0, regIndex} == IDX_REQ_DELTA)) begin
            next_requestDelta = 1'b0;
        end
        if (readAccess && mapped
            && ({2'h0, regIndex} == IDX_BUSY_DELTA)) begin
            next_busyDelta = 1'b0;
        end
        // set wins over a clear in the same cycle
        // any request sets delta
        if (swapRequest) begin
            next_requestDelta = 1'b1;
        end
        if (busyFell) begin
            next_busyDelta = 1'b1;
        end
        next_irqReg = (next_requestDelta & requestMask)
            | (next_busyDelta & busyMask);
        // read data is captured in the setup cycle, valid in access phase
        if (psel && !penable && !pwrite) begin
            next_readData = '0;
            if (addrAligned) begin
                case ({2'h0, regIndex})
                    IDX_REVISION: begin
                        next_readData[REV_W-1:0] = REVISION_CODE;
                    end
                    IDX_IRQ_LOW: begin
                        next_readData[IRQ_HALF_W-1:0] =
                            compositeIrq[IRQ_HALF_W-1:0];
                    end
                    IDX_IRQ_HIGH: begin
                        next_readData[IRQ_HALF_W-1:0] =
                            compositeIrq[IRQ_IN_W-1:IRQ_HALF_W];
                    end
                    IDX_SOFT_RESET: begin
                        next_readData[BIT_LSB] = softReset;
                    end
                    IDX_SWAP_CONTROL: begin
                        next_readData[BIT_REQ_MASK] = requestMask;
                        next_readData[BIT_BUSY] = swapBusy;
                        next_readData[BIT_LOCK] = swapLock;
                        next_readData[BIT_HOLD] = swapHold;
                        next_readData[BIT_BUSY_MASK] = busyMask;
                    end
                    IDX_REQ_DELTA: begin
                        // includes an event landing this very cycle
                        next_readData[BIT_LSB] = requestDelta | swapRequest;
                    end
                    IDX_BUSY_DELTA: begin
                        next_readData[BIT_LSB] = busyDelta | busyFell;
                    end
                    default: begin
                        next_readData = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (coreRst) begin
            requestMask <= RST_CTRL_BIT;
            busyMask <= RST_CTRL_BIT;
            swapLock <= RST_CTRL_BIT;
            swapHold <= RST_CTRL_BIT;
            requestDelta <= RST_DELTA;
            busyDelta <= RST_DELTA;
            irqReg <= 1'b0;
        end else begin
            requestMask <= next_requestMask;
            busyMask <= next_busyMask;
            swapLock <= next_swapLock;
            swapHold <= next_swapHold;
            requestDelta <= next_requestDelta;
            busyDelta <= next_busyDelta;
            irqReg <= next_irqReg;
        end
    end

    // bus answer stays alive under soft reset, so software can still
    // read the reset bit back and clear it; only srst empties it
    always_ff @(posedge clk) begin
        if (srst) begin
            readData <= '0;
        end else begin
            readData <= next_readData;
        end
    end

    assign irqOut = irqReg;
endmodule

// ### common/gcc_pkg.sv
package gcc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_REVISION = 8'h17;
    localparam logic [7:0] IDX_IRQ_LOW = 8'h18;
    localparam logic [7:0] IDX_IRQ_HIGH = 8'h19;
    localparam logic [7:0] IDX_SOFT_RESET = 8'h1A;
    localparam logic [7:0] IDX_SWAP_CONTROL = 8'h1B;
    localparam logic [7:0] IDX_REQ_DELTA = 8'h1C;
    localparam logic [7:0] IDX_BUSY_DELTA = 8'h1D;
    localparam logic [7:0] IDX_SWAP_TRIGGER = 8'h1E;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int REV_W = 8;
    localparam int IRQ_IN_W = 32;
    localparam int IRQ_HALF_W = 16;

    // swap control register field positions
    localparam int BIT_REQ_MASK = 0;
    localparam int BIT_BUSY = 1;
    localparam int BIT_LOCK = 2;
    localparam int BIT_HOLD = 3;
    localparam int BIT_BUSY_MASK = 4;
    // single-bit registers use bit 0
    localparam int BIT_LSB = 0;

    // reset values
    localparam logic RST_SOFT_RESET = 1'b0;
    localparam logic RST_CTRL_BIT = 1'b0;
    localparam logic RST_DELTA = 1'b0;

    // arbitrary neutral revision value
    localparam logic [REV_W-1:0] REVISION_DEFAULT = 8'h31;

    typedef enum {
        SWAP_IDLE,
        SWAP_WAIT_FRAME
    } swap_state_t;
endpackage

// ### rtl/pin_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser with rising-edge pulse after the second stage
module pin_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pinIn,
    output logic levelOut,
    output logic risePulse
);
    logic stage1;
    logic stage2;
    logic stage3;
    logic next_stage1;
    logic next_stage2;
    logic next_stage3;

    // first stage feeds only the second one
    always_comb begin
        next_stage1 = pinIn;
        next_stage2 = stage1;
        next_stage3 = stage2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
        end
    end

    assign levelOut = stage2;
    assign risePulse = stage2 & ~stage3;
endmodule

// ### rtl/swap_sequencer.sv
`timescale 1ns/10ps
// issues the swap pulse and tracks busy until the next frame boundary
module swap_sequencer
    import gcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic request,
    input wire logic swapLock,
    input wire logic frameBoundary,
    output logic swapPulse,
    output logic swapBusy,
    output logic busyFell
);
    swap_state_t state;
    swap_state_t next_state;
    logic next_swapPulse;
    logic next_busyFell;

    always_comb begin
        next_state = state;
        next_swapPulse = 1'b0;
        next_busyFell = 1'b0;
        case (state)
            SWAP_IDLE: begin
                if (request && !swapLock) begin
                    next_swapPulse = 1'b1;
                    next_state = SWAP_WAIT_FRAME;
                end
            end
            SWAP_WAIT_FRAME: begin
                // a repeat request while busy re-issues, boundary not yet due
                if (request && !swapLock) begin
                    next_swapPulse = 1'b1;
                end else if (frameBoundary && !swapPulse) begin
                    next_state = SWAP_IDLE;
                    next_busyFell = 1'b1;
                end
            end
            default: begin
                next_state = SWAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SWAP_IDLE;
            swapPulse <= 1'b0;
            busyFell <= 1'b0;
        end else begin
            state <= next_state;
            swapPulse <= next_swapPulse;
            busyFell <= next_busyFell;
        end
    end

    assign swapBusy = (state == SWAP_WAIT_FRAME);
endmodule

// ### verif/global_control_config_swap_sva.sv
`timescale 1ns/10ps
// port-level checker for the control and swap register group
module gccs_checker
    import gcc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gcc_pkg::ADDR_W-1:0] paddr,
    input wire logic [gcc_pkg::DATA_W-1:0] pwdata,
    input wire logic [gcc_pkg::DATA_W-1:0] prdata,
    input wire logic [gcc_pkg::IRQ_IN_W-1:0] compositeIrq,
    input wire logic swapRequestPin,
    input wire logic swapPulseOut,
    input wire logic deviceReset,
    input wire logic irqOut
);
    // access-phase decode shared by the properties
    wire acc = psel & penable;
    wire rd = acc & !pwrite;
    wire wr = acc & pwrite;
    wire clr = acc && paddr inside {8'h68, 8'h6C, 8'h70, 8'h74};

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    chk_view_low: assert property (rd && paddr == 8'h60 |->
        prdata == {16'h0000, $past(compositeIrq[15:0])})
        else $error("low view mismatch");
    chk_soft_hold: assert property (wr && paddr == 8'h68 && pwdata[0]
        |=> deviceReset [*2]) else $error("soft reset not held");
    chk_held_quiet: assert property (deviceReset |=>
        !swapPulseOut && !irqOut) else $error("activity while in reset");
    chk_soft_release: assert property (wr && paddr == 8'h68 &&
        !pwdata[0] |=> !deviceReset) else $error("soft reset stuck");
    chk_pulse_cause: assert property (swapPulseOut |->
        $past(wr && paddr == 8'h78) || $past(swapRequestPin, 3))
        else $error("pulse without request");
    chk_pulse_width: assert property (swapPulseOut |=> !swapPulseOut)
        else $error("pulse too long");
    chk_trig_reads: assert property (rd && paddr == 8'h78 |->
        prdata == 32'h00000000) else $error("trigger reads nonzero");
    chk_delta_width: assert property (rd && paddr inside {8'h70, 8'h74}
        |-> prdata[31:1] == 31'h0) else $error("delta upper bits set");
    chk_irq_fall: assert property ($fell(irqOut) |->
        $past(clr) || $past(clr, 2)) else $error("irq dropped unprompted");
endmodule

bind global_control_config_swap gccs_checker chk (.clk, .srst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .compositeIrq,
    .swapRequestPin, .swapPulseOut, .deviceReset, .irqOut);

// ### verif/core_frame_model.sv
`timescale 1ns/10ps
// core stand-in: boundary every gap+1 cycles; gap 8'hFF stalls the core
module core_frame_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] gap,
    output logic frameBoundary
);
    logic [7:0] cnt, next_cnt;
    logic next_fb;
    // a stalled core never ends a frame, so busy can be held on purpose
    always_comb begin
        next_cnt = (cnt >= gap) ? 8'h00 : cnt + 8'h01;
        next_fb = (cnt == gap) && (gap != 8'hFF);
        if (srst) begin
            next_cnt = 8'h00;
            next_fb = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        cnt <= next_cnt;
        frameBoundary <= next_fb;
    end
endmodule

// ### verif/global_control_config_swap_tb.sv
`timescale 1ns/10ps
module global_control_config_swap_tb;
    import gcc_pkg::*;
    logic clk, srst, psel, penable, pwrite, pready, pslverr;
    logic pin, fb, pulse, devRst, irq, e;
    logic [7:0] paddr, gap;
    logic [31:0] pwdata, prdata, irqIn, r;
    int nErrors = 0;
    int checksDone = 0;
    int nPulses = 0;

    global_control_config_swap uut (.clk, .srst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .compositeIrq(irqIn),
        .swapRequestPin(pin), .frameBoundary(fb), .swapPulseOut(pulse),
        .deviceReset(devRst), .irqOut(irq));
    core_frame_model core (.clk, .srst, .gap, .frameBoundary(fb));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // pulses as the core sees them
    always @(posedge clk) begin
        if (pulse === 1'b1) nPulses++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        if (nErrors == 0 && checksDone > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one APB transfer; an idle edge first so no strobe is driven twice
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1) begin
            nErrors++;
            report_and_stop();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    task automatic wait_fb();
        int i;
        for (i = 0; i < 500 && fb !== 1'b1; i++) @(posedge clk);
        if (fb !== 1'b1) begin
            nErrors++;
            report_and_stop();
        end
    endtask

    // revision, read-only and write-only places, hold storage, hole
    task automatic t_regs();
        rd(8'h5C, {24'h0, REVISION_DEFAULT});
        rd(8'h68, 32'h0);
        xfer(1'b1, 8'h6C, 32'h0000FFFF);
        rd(8'h6C, 32'h0000001D);
        rd(8'h78, 32'h0);
        xfer(1'b0, 8'h7C, 32'h0);
        chk({r[30:0], e}, 32'h1);
        xfer(1'b1, 8'h6C, 32'h0);
    endtask

    // both halves of the composite inputs, two patterns
    task automatic t_view();
        for (int k = 0; k < 2; k++) begin
            irqIn <= k ? 32'h5A3CC3A5 : 32'hA5C33C5A;
            rd(8'h60, k ? 32'hC3A5 : 32'h3C5A);
            rd(8'h64, k ? 32'h5A3C : 32'hA5C3);
        end
    endtask

    // trigger, busy until boundary, deltas feed the masked irq
    task automatic t_swap();
        int n;
        n = nPulses;
        xfer(1'b1, 8'h6C, 32'h11);
        xfer(1'b1, 8'h78, 32'h0);
        rd(8'h6C, 32'h13);
        chk(nPulses, n + 1);
        chk(irq, 1'b1);
        rd(8'h70, 32'h1);
        rd(8'h70, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        gap <= 8'h03;
        wait_fb();
        gap <= 8'hFF;
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        rd(8'h6C, 32'h11);
        rd(8'h74, 32'h1);
        rd(8'h74, 32'h0);
    endtask

    // lock stops pin and trigger pulses but not the delta
    task automatic t_lock();
        int n;
        n = nPulses;
        xfer(1'b1, 8'h6C, 32'h04);
        pin <= 1'b1;
        repeat (8) @(posedge clk);
        pin <= 1'b0;
        xfer(1'b1, 8'h78, 32'h0);
        repeat (3) @(posedge clk);
        chk(nPulses, n);
        chk(irq, 1'b0);
        xfer(1'b1, 8'h6C, 32'h01);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        rd(8'h70, 32'h1);
        pin <= 1'b1;
        repeat (8) @(posedge clk);
        pin <= 1'b0;
        chk(nPulses, n + 1);
        rd(8'h70, 32'h1);
    endtask

    // soft reset clears control state; release lets swaps run again
    task automatic t_soft();
        int n;
        xfer(1'b1, 8'h6C, 32'h1D);
        xfer(1'b1, 8'h68, 32'h1);
        @(posedge clk);
        chk(devRst, 1'b1);
        rd(8'h6C, 32'h0);
        rd(8'h68, 32'h1);
        xfer(1'b1, 8'h68, 32'h0);
        @(posedge clk);
        chk(devRst, 1'b0);
        n = nPulses;
        xfer(1'b1, 8'h78, 32'h0);
        repeat (3) @(posedge clk);
        chk(nPulses, n + 1);
    endtask

    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        irqIn = 32'h0;
        pin = 1'b0;
        gap = 8'hFF;
        repeat (16) @(posedge clk);
        chk(devRst, 1'b1);
        srst <= 1'b0;
        t_regs();
        t_view();
        t_swap();
        t_lock();
        t_soft();
        report_and_stop();
    end
endmodule
